// ---- logic/ulms_pkg.sv ----
// Package with register map, field positions and reset values.
`default_nettype none
package ulms_pkg;
  // --------------------------------------------------------------------
  // Register byte offsets
  // --------------------------------------------------------------------
  localparam logic [7:0] ADDR_RX_BUFFER   = 8'h00;
  localparam logic [7:0] ADDR_LINE_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MODEM_STAT  = 8'h08;
  localparam logic [7:0] ADDR_CONTROL     = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'h14;
  localparam logic [7:0] ADDR_RX_COUNT    = 8'h18;
  // --------------------------------------------------------------------
  // Line status field positions
  // --------------------------------------------------------------------
  localparam int LS_FIFO_ERR  = 7;
  localparam int LS_TX_ALLEMP = 6;
  localparam int LS_TX_FEMP   = 5;
  localparam int LS_BREAK     = 4;
  localparam int LS_FRAME     = 3;
  localparam int LS_PARITY    = 2;
  localparam int LS_OVERRUN   = 1;
  localparam int LS_DATA      = 0;
  // --------------------------------------------------------------------
  // Modem status field positions
  // --------------------------------------------------------------------
  localparam int MS_DCD     = 7;
  localparam int MS_RI      = 6;
  localparam int MS_DSR     = 5;
  localparam int MS_CTS     = 4;
  localparam int MS_CHG_LSB = 0;
  // --------------------------------------------------------------------
  // Control fields, interrupt bits and reset values
  // --------------------------------------------------------------------
  localparam int CTL_FIFO_EN  = 0;
  localparam int CTL_RX_CLR   = 1;
  localparam int IRQ_RX_DATA  = 0;
  localparam int IRQ_LINE_ERR = 1;
  localparam int IRQ_MODEM    = 2;
  localparam int IRQ_W        = 3;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  localparam logic [3:0] MODEM_LVL_RST = 4'h0;
endpackage
`default_nettype wire

// ---- logic/ulms_rx_fifo.sv ----
// Receive FIFO holding data byte plus parity, framing and break flags.
`default_nettype none
module ulms_rx_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Control.
  input  wire logic             clear,
  input  wire logic [3:0]       limit,
  // Write side.
  input  wire logic             wr_valid,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic                  wr_ready,
  // Read side.
  input  wire logic             rd_pop,
  output logic                  rd_valid,
  output logic [WIDTH-1:0]      rd_data,
  // Status.
  output logic [3:0]            count,
  output logic                  any_err
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    rptr_r;
  logic [AW-1:0]    wptr_r;
  logic [3:0]       cnt_r;
  logic             push;
  logic             pop;
  logic [DEPTH-1:0] err_vec;

  // Handshake terms; a limit of one makes it act as a one-entry buffer.
  assign wr_ready = (cnt_r < limit);
  assign rd_valid = (cnt_r != 4'h0);
  assign push     = wr_valid && wr_ready;
  assign pop      = rd_pop && rd_valid;
  assign rd_data  = mem[rptr_r];
  assign count    = cnt_r;

  // Per-slot error presence for held entries only.
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      err_vec[i] = 1'b0;
      if (4'(i) < cnt_r) begin
        err_vec[i] = |mem[AW'(32'(rptr_r) + i)][WIDTH-1:8];
      end
    end
  end
  assign any_err = |err_vec;

  // Storage array.
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wptr_r] <= wr_data;
    end
  end

  // Pointers and occupancy.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rptr_r <= '0;
      wptr_r <= '0;
      cnt_r  <= 4'h0;
    end else if (clear) begin
      rptr_r <= '0;
      wptr_r <= '0;
      cnt_r  <= 4'h0;
    end else begin
      if (push) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= rptr_r + 1'b1;
      end
      cnt_r <= cnt_r + {3'h0, push} - {3'h0, pop};
    end
  end
endmodule
`default_nettype wire

// ---- logic/ulms_status.sv ----
// Line status, modem status and receive buffer block behind APB.
//
// Functional notes
// - Line status bit 7 set while any held receive entry has an error.
// - Bit 6 high only while holding stage and transmit shifter empty.
// - Bit 5 high while transmit FIFO is empty; not reset, follows the input.
// - Bit 4 set when a break is detected on the receive line.
// - Bit 3 shows framing error of the character being read.
// - Bit 2 shows parity error of the character being read.
// - Bit 1 set when a received character could not be stored.
// - Bit 0 high while receive FIFO holds data, clears when empty.
// - Modem bits 7 and 6 show carrier detect and ring, inverted from the active low pins.
// - Modem bits 5 and 4 show data set ready and clear to send.
// - Modem bits 3..0 flag a change of each modem input.
// - Modem status exists only on instance zero.
// - With FIFO on, characters are queued and read in arrival order.
// - FIFO enable selects 8 entries, otherwise single-byte buffer.
`default_nettype none
module ulms_status #(
  parameter int INSTANCE = 0,
  parameter int DEPTH    = 8
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Receiver character input.
  input  wire logic        rx_char_valid,
  input  wire logic [7:0]  rx_char_data,
  input  wire logic        rx_char_parity_err,
  input  wire logic        rx_char_framing_err,
  input  wire logic        rx_char_break,
  // Transmitter state.
  input  wire logic        tx_holding_empty,
  input  wire logic        tx_shift_empty,
  input  wire logic        tx_fifo_is_empty,
  // Modem pins, active low.
  input  wire logic        carrier_detect_n,
  input  wire logic        ring_indicator_n,
  input  wire logic        data_set_ready_n,
  input  wire logic        clear_to_send_n,
  // Interrupt.
  output logic             irq
);
  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  localparam bit HAS_MODEM = (INSTANCE == 0);

  logic        acc;
  logic        rd_acc;
  logic        wr_acc;
  logic        sel_rbr;
  logic        sel_lsr;
  logic        sel_msr;
  logic        sel_ctl;
  logic        sel_ist;
  logic        sel_imk;
  logic        sel_cnt;
  logic        mapped;

  // Every transfer completes in its first access cycle.
  assign pready  = 1'b1;
  assign acc     = psel && penable;
  assign rd_acc  = acc && !pwrite;
  assign wr_acc  = acc && pwrite;
  assign sel_rbr = (paddr == ulms_pkg::ADDR_RX_BUFFER);
  assign sel_lsr = (paddr == ulms_pkg::ADDR_LINE_STATUS);
  assign sel_msr = (paddr == ulms_pkg::ADDR_MODEM_STAT) && HAS_MODEM;
  assign sel_ctl = (paddr == ulms_pkg::ADDR_CONTROL);
  assign sel_ist = (paddr == ulms_pkg::ADDR_IRQ_STATUS);
  assign sel_imk = (paddr == ulms_pkg::ADDR_IRQ_MASK);
  assign sel_cnt = (paddr == ulms_pkg::ADDR_RX_COUNT);
  assign mapped  = sel_rbr | sel_lsr | sel_msr | sel_ctl | sel_ist |
                   sel_imk | sel_cnt;
  assign pslverr = acc && !mapped;

  // --------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------
  logic [7:0]  ctl_r;
  logic        fifo_en;
  logic        rx_clear;

  assign fifo_en  = ctl_r[ulms_pkg::CTL_FIFO_EN];
  assign rx_clear = wr_acc && sel_ctl && pstrb[0] &&
                    pwdata[ulms_pkg::CTL_RX_CLR];

  // Enable bit is stored, the clear bit is a write-only pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= ulms_pkg::CONTROL_RST;
    end else if (wr_acc && sel_ctl && pstrb[0]) begin
      ctl_r <= {7'h00, pwdata[ulms_pkg::CTL_FIFO_EN]};
    end
  end

  // --------------------------------------------------------------------
  // Receive FIFO
  // --------------------------------------------------------------------
  logic [10:0] ff_wdata;
  logic [10:0] ff_rdata;
  logic        ff_ready;
  logic        ff_valid;
  logic [3:0]  ff_count;
  logic        ff_anyerr;
  logic [3:0]  ff_limit;
  logic        rbr_read;

  assign ff_limit = fifo_en ? 4'(DEPTH) : 4'h1;
  assign ff_wdata = {rx_char_break, rx_char_framing_err,
                     rx_char_parity_err, rx_char_data};
  assign rbr_read = rd_acc && sel_rbr;

  ulms_rx_fifo #(
    .WIDTH (11),
    .DEPTH (DEPTH)
  ) u_rx_fifo (
    .pclk     (pclk),
    .presetn  (presetn),
    .clear    (rx_clear),
    .limit    (ff_limit),
    .wr_valid (rx_char_valid),
    .wr_data  (ff_wdata),
    .wr_ready (ff_ready),
    .rd_pop   (rbr_read),
    .rd_valid (ff_valid),
    .rd_data  (ff_rdata),
    .count    (ff_count),
    .any_err  (ff_anyerr)
  );

  // --------------------------------------------------------------------
  // Line status
  // --------------------------------------------------------------------
  logic        brk_r;
  logic        ovr_r;
  logic        lsr_read;
  logic        overflow;
  logic [7:0]  lsr_val;

  assign lsr_read = rd_acc && sel_lsr;
  assign overflow = rx_char_valid && !ff_ready;

  // read clears, set wins
  // A read clears only the bits that its captured data reported, so a flag
  // raised between the setup capture and the access phase is not lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_r <= 1'b0;
      ovr_r <= 1'b0;
    end else begin
      brk_r <= (rx_char_valid && rx_char_break) ||
               (brk_r && !(lsr_read && prdata[ulms_pkg::LS_BREAK]));
      ovr_r <= overflow ||
               (ovr_r && !(lsr_read && prdata[ulms_pkg::LS_OVERRUN]));
    end
  end

  always_comb begin
    lsr_val                          = 8'h00;
    lsr_val[ulms_pkg::LS_FIFO_ERR]   = ff_anyerr;
    lsr_val[ulms_pkg::LS_TX_ALLEMP]  = tx_holding_empty && tx_shift_empty;
    lsr_val[ulms_pkg::LS_TX_FEMP]    = tx_fifo_is_empty;
    lsr_val[ulms_pkg::LS_BREAK]      = brk_r;
    lsr_val[ulms_pkg::LS_FRAME]      = ff_valid && ff_rdata[9];
    lsr_val[ulms_pkg::LS_PARITY]     = ff_valid && ff_rdata[8];
    lsr_val[ulms_pkg::LS_OVERRUN]    = ovr_r;
    lsr_val[ulms_pkg::LS_DATA]       = ff_valid;
  end

  // --------------------------------------------------------------------
  // Modem status
  // --------------------------------------------------------------------
  logic [3:0]  mlvl_r;
  logic [3:0]  mchg_r;
  logic [3:0]  mlvl_now;
  logic        msr_read;
  logic [7:0]  msr_val;

  assign mlvl_now = HAS_MODEM ? {~carrier_detect_n, ~ring_indicator_n,
                                 ~data_set_ready_n, ~clear_to_send_n}
                              : 4'h0;
  assign msr_read = rd_acc && sel_msr;
  assign msr_val  = HAS_MODEM ? {mlvl_r, mchg_r} : 8'h00;

  // change flags, set wins over read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mlvl_r <= ulms_pkg::MODEM_LVL_RST;
      mchg_r <= 4'h0;
    end else begin
      mlvl_r <= mlvl_now;
      mchg_r <= (mlvl_now ^ mlvl_r) |
                (mchg_r & ~({4{msr_read}} & prdata[3:0]));
    end
  end

  // --------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------
  logic [2:0]  ist_r;
  logic [2:0]  imk_r;
  logic [2:0]  ev;
  logic        ist_read;

  assign ev[ulms_pkg::IRQ_RX_DATA]  = rx_char_valid && ff_ready;
  assign ev[ulms_pkg::IRQ_LINE_ERR] = overflow ||
         (rx_char_valid && (rx_char_break || rx_char_framing_err ||
                            rx_char_parity_err));
  assign ev[ulms_pkg::IRQ_MODEM]    = |(mlvl_now ^ mlvl_r);
  assign ist_read = rd_acc && sel_ist;
  assign irq      = |(ist_r & imk_r);

  // Sticky events cleared by reading, mask written by software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_r <= 3'h0;
      imk_r <= ulms_pkg::IRQ_MASK_RST;
    end else begin
      ist_r <= ev | (ist_r & ~({3{ist_read}} & prdata[2:0]));
      if (wr_acc && sel_imk && pstrb[0]) begin
        imk_r <= pwdata[2:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  logic [7:0]  rd_mux;

  // software reads only with data present
  always_comb begin
    rd_mux = 8'h00;
    if (sel_rbr) begin
      rd_mux = ff_rdata[7:0];
    end else if (sel_lsr) begin
      rd_mux = lsr_val;
    end else if (sel_msr) begin
      rd_mux = msr_val;
    end else if (sel_ctl) begin
      rd_mux = ctl_r;
    end else if (sel_ist) begin
      rd_mux = {5'h00, ist_r};
    end else if (sel_imk) begin
      rd_mux = {5'h00, imk_r};
    end else if (sel_cnt) begin
      rd_mux = {4'h0, ff_count};
    end
  end

  // Read data registered in the setup cycle of a read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, rd_mux};
    end
  end
endmodule
`default_nettype wire

// ---- bench/ulms_status_props.sv ----
// Checker of the status block ports, with its bind.
`default_nettype none
module ulms_status_props (
  // Clock, reset and bus.
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Receiver and transmitter state.
  input wire logic        rx_char_valid,
  input wire logic        rx_char_break,
  input wire logic        tx_holding_empty,
  input wire logic        tx_shift_empty,
  input wire logic        tx_fifo_is_empty,
  // Modem pins.
  input wire logic        carrier_detect_n,
  input wire logic        ring_indicator_n,
  input wire logic        data_set_ready_n,
  input wire logic        clear_to_send_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] pins_d;
  logic [3:0] chg_q;
  logic [3:0] chg_pend;
  logic       brk_pend;
  // Read setups and accesses of the two status registers.
  wire        rd_set = psel && !penable && !pwrite;
  wire        acc = psel && penable;
  wire        ls_set = rd_set && paddr == ulms_pkg::ADDR_LINE_STATUS;
  wire        ms_set = rd_set && paddr == ulms_pkg::ADDR_MODEM_STAT;
  wire        ls_acc = acc && paddr == ulms_pkg::ADDR_LINE_STATUS;
  wire        ms_acc = acc && paddr == ulms_pkg::ADDR_MODEM_STAT;
  wire [3:0]  pins = {carrier_detect_n, ring_indicator_n,
                      data_set_ready_n, clear_to_send_n};
  wire        still = pins == pins_d && chg_q == 4'h0;
  // Events not yet seen by a read; a clear wins to stay conservative.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_d   <= 4'hF;
      chg_q    <= 4'h0;
      chg_pend <= 4'h0;
      brk_pend <= 1'b0;
    end else begin
      pins_d   <= pins;
      chg_q    <= pins ^ pins_d;
      chg_pend <= (chg_pend | chg_q) & ~{4{ms_acc}};
      brk_pend <= (brk_pend | (rx_char_valid && rx_char_break)) && !ls_acc;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_tx_all;
    ls_set && $stable(tx_holding_empty && tx_shift_empty)
      |=> prdata[6] == $past(tx_holding_empty && tx_shift_empty);
  endproperty
  a_tx_all: assert property (p_tx_all) else $error("tx all empty");
  property p_tx_fifo;
    ls_set && $stable(tx_fifo_is_empty)
      |=> prdata[5] == $past(tx_fifo_is_empty);
  endproperty
  a_tx_fifo: assert property (p_tx_fifo) else $error("tx fifo empty");
  property p_brk;
    ls_set && brk_pend |=> prdata[4];
  endproperty
  a_brk: assert property (p_brk) else $error("break lost");
  property p_dcd_ri;
    ms_set && still |=> prdata[7:6] == ~$past(pins[3:2]);
  endproperty
  a_dcd_ri: assert property (p_dcd_ri) else $error("dcd ri level");
  property p_dsr_cts;
    ms_set && still |=> prdata[5:4] == ~$past(pins[1:0]);
  endproperty
  a_dsr_cts: assert property (p_dsr_cts) else $error("dsr cts");
  property p_chg;
    ms_set |=> (prdata[3:0] & $past(chg_pend)) == $past(chg_pend);
  endproperty
  a_chg: assert property (p_chg) else $error("change flag lost");
  property p_map;
    ms_acc |-> !pslverr;
  endproperty
  a_map: assert property (p_map) else $error("modem unmapped");
  property p_hold;
    !rd_set |=> $stable(prdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  // Main scenarios.
  c_brk: cover property (ls_set && brk_pend);
  c_chg: cover property (ms_set && chg_pend != 4'h0);
  c_err: cover property (acc && pslverr);
endmodule
bind ulms_status ulms_status_props u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pslverr,
  .rx_char_valid, .rx_char_break, .tx_holding_empty, .tx_shift_empty,
  .tx_fifo_is_empty, .carrier_detect_n, .ring_indicator_n,
  .data_set_ready_n, .clear_to_send_n
);
`default_nettype wire

// ---- bench/ulms_far_model.sv ----
// Far side model: characters, modem pins, transmitter state.
`default_nettype none
module ulms_far_model (
  // Clock.
  input  wire logic  pclk,
  // Characters toward the block, flags are break, framing, parity.
  output logic       rx_char_valid,
  output logic [7:0] rx_char_data,
  output logic [2:0] rx_char_flags,
  // Transmitter state and active low modem pins.
  output logic [2:0] tx_state,
  output logic [3:0] modem_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Lines start idle; modem pins rest high.
  initial begin
    rx_char_valid = 1'b0;
    rx_char_data  = 8'h00;
    rx_char_flags = 3'h0;
    tx_state      = 3'h7;
    modem_n       = 4'hF;
  end
  // One cycle pulse; qualifiers turn to garbage after it.
  task automatic send(input logic [7:0] b, input logic [2:0] e);
    @(posedge pclk);
    rx_char_valid <= 1'b1;
    rx_char_data  <= b;
    rx_char_flags <= e;
    @(posedge pclk);
    rx_char_valid <= 1'b0;
    rx_char_data  <= ~b;
    rx_char_flags <= ~e;
  endtask
  // Moves transmitter state and modem pins together.
  task automatic set_lines(input logic [2:0] t, input logic [3:0] m);
    @(posedge pclk);
    tx_state <= t;
    modem_n  <= m;
  endtask
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench of the status block against a queue model.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, got;
  logic        pready, pslverr, irq, rv, err;
  logic [7:0]  rd;
  logic [2:0]  rf, tx, txv;
  logic [3:0]  mn, m, chg, mlast;
  logic [10:0] q[$];
  int          bad_count = 0, check_count = 0, brk, ovr, depth;
  ulms_status #(.INSTANCE(0), .DEPTH(8)) u_ulms_status (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hF), .prdata, .pready, .pslverr, .rx_char_valid(rv),
    .rx_char_data(rd), .rx_char_parity_err(rf[0]),
    .rx_char_framing_err(rf[1]), .rx_char_break(rf[2]),
    .tx_holding_empty(tx[2]), .tx_shift_empty(tx[1]),
    .tx_fifo_is_empty(tx[0]), .carrier_detect_n(mn[3]),
    .ring_indicator_n(mn[2]), .data_set_ready_n(mn[1]),
    .clear_to_send_n(mn[0]), .irq);
  ulms_far_model u_ulms_far_model (.pclk, .rx_char_valid(rv),
    .rx_char_data(rd), .rx_char_flags(rf), .tx_state(tx), .modem_n(mn));
  initial begin
    forever #25 pclk = ~pclk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] s, e, input string t);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %0t %s seen %h want %h", $time, t, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) bad_count++;
    got = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  function automatic logic [31:0] ls_exp();
    logic [31:0] e;
    e = {25'h0, txv[2] & txv[1], txv[0], brk[0], 2'h0, ovr[0], 1'b0};
    foreach (q[i]) if (q[i][10:8] != 0) e[7] = 1;
    if (q.size() > 0) e[3:0] = {q[0][9], q[0][8], ovr[0], 1'b1};
    return e;
  endfunction
  task automatic rd_ls();
    apb(0, ulms_pkg::ADDR_LINE_STATUS, 0);
    check(got, ls_exp(), "line status");
    brk = 0;
    ovr = 0;
  endtask
  task automatic push(input logic [7:0] b, input logic [2:0] e);
    u_ulms_far_model.send(b, e);
    if (e[2]) brk = 1;
    if (q.size() < depth) q.push_back({e, b});
    else ovr = 1;
  endtask
  task automatic pop();
    apb(0, ulms_pkg::ADDR_RX_BUFFER, 0);
    check(got, {24'h0, q[0][7:0]}, "rx byte");
    void'(q.pop_front());
  endtask
  initial begin
    #2000000;
    bad_count++;
    close_out();
  end
  initial begin
    void'($urandom(32'h2FE9));
    {depth, brk, ovr, chg, mlast, txv} = {32'd1, 64'd0, 4'h0, 4'hF, 3'h7};
    repeat (8) @(posedge pclk);
    presetn <= 1;
    rd_ls();
    apb(0, ulms_pkg::ADDR_CONTROL, 0);
    check(got, 0, "control reset");
    apb(0, ulms_pkg::ADDR_IRQ_MASK, 0);
    check(got, 0, "mask reset");
    repeat (6) begin
      txv = 3'($urandom);
      u_ulms_far_model.set_lines(txv, mlast);
      rd_ls();
    end
    $display("test reset and transmit flags done");
    apb(1, ulms_pkg::ADDR_CONTROL, 1);
    depth = 8;
    for (int i = 0; i < 9; i++)
      push(8'($urandom), i == 8 ? 3'h0 : 3'($urandom));
    apb(0, ulms_pkg::ADDR_RX_COUNT, 0);
    check(got, 8, "rx count");
    rd_ls();
    while (q.size() > 0) begin
      pop();
      rd_ls();
    end
    $display("test fifo order and errors done");
    apb(1, ulms_pkg::ADDR_CONTROL, 0);
    depth = 1;
    push(8'h3C, 3'h0);
    push(8'hC3, 3'h0);
    rd_ls();
    pop();
    rd_ls();
    $display("test single byte buffer done");
    repeat (6) begin
      m = 4'($urandom);
      chg = chg | (m ^ mlast);
      mlast = m;
      u_ulms_far_model.set_lines(txv, m);
      repeat (3) @(posedge pclk);
      apb(0, ulms_pkg::ADDR_MODEM_STAT, 0);
      check(got, {24'h0, ~m, chg}, "modem status");
      check(err, 0, "modem mapped");
      chg = 0;
    end
    $display("test modem status done");
    apb(0, ulms_pkg::ADDR_IRQ_STATUS, 0);
    apb(1, ulms_pkg::ADDR_IRQ_MASK, 0);
    push(8'hA5, 3'h0);
    @(negedge pclk);
    check(irq, 0, "irq masked");
    apb(1, ulms_pkg::ADDR_IRQ_MASK, 1);
    @(negedge pclk);
    check(irq, 1, "irq raised");
    apb(0, ulms_pkg::ADDR_IRQ_STATUS, 0);
    check(got[0], 1, "irq status");
    @(negedge pclk);
    check(irq, 0, "irq cleared");
    apb(1, ulms_pkg::ADDR_CONTROL, 2);
    q.delete();
    rd_ls();
    apb(0, 8'h1C, 0);
    check(err, 1, "unmapped error");
    check(got, 0, "unmapped data");
    $display("test interrupt and unmapped done");
    close_out();
  end
endmodule
`default_nettype wire
